// >>> tcc_timer_map.svh
// Purpose: constants for the capture/compare timer
// Assumes: included by bare name
// Notes:   definitions only
`ifndef TCC_TIMER_MAP_SVH
`define TCC_TIMER_MAP_SVH

// ------------------------------------------------------------
// structure
// ------------------------------------------------------------
`define TCC_NUM_CH        6
`define TCC_CNT_W         16

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define TCC_CNT_RST       16'h0000
`define TCC_MOD_RST       16'hffff
`define TCC_VAL_RST       16'h0000
`define TCC_DIV_RST       6'h00

// ------------------------------------------------------------
// field encodings
// ------------------------------------------------------------
`define TCC_PSEL_EXT      3'h7
`define TCC_ACT_NONE      2'h0
`define TCC_ACT_TOGGLE    2'h1
`define TCC_ACT_CLEAR     2'h2
`define TCC_ACT_SET       2'h3
`define TCC_EDGE_RISE_BIT 0
`define TCC_EDGE_FALL_BIT 1

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define TCC_CLK_KHZ       10000
`define TCC_EXT_MAX_KHZ   4000
`define TCC_EXT_MIN_CYC   ((`TCC_CLK_KHZ + `TCC_EXT_MAX_KHZ - 1) / `TCC_EXT_MAX_KHZ)

`endif

// >>> tcc_pkg.sv
// Purpose: shared types of the capture/compare timer
// Assumes: constants live in tcc_timer_map.svh
// Notes:   types only
`default_nettype none

package tcc_pkg;
   typedef logic [15:0] tcc_cnt_t;
   typedef enum logic {
      TCC_BSEL_CH0,
      TCC_BSEL_CH1
   } tcc_bsel_t;
endpackage : tcc_pkg

`default_nettype wire

// >>> tcc_ch_if.sv
// Purpose: bundle between the timer core and one channel
// Assumes: one instance per channel
// Notes:   ctl side is the shared counter logic
`default_nettype none

interface tcc_ch_if;
   import tcc_pkg::*;
   logic       clk_en;
   logic       tick_run;
   logic       ovf_evt;
   logic       brk;
   logic       ms;
   logic       en;
   logic       tov;
   logic       wr;
   logic       flag_clr;
   logic       pin_in;
   logic [1:0] edge_act;
   tcc_cnt_t   cnt;
   tcc_cnt_t   cnt_next;
   tcc_cnt_t   wdata;
   tcc_cnt_t   cmp_val;
   tcc_cnt_t   val;
   logic       flag;
   logic       pin_out;
   logic       pin_oe;
   logic       match;
   modport ctl  (output clk_en, tick_run, ovf_evt, brk, ms, en, tov, wr, flag_clr, pin_in, edge_act,
                 cnt, cnt_next, wdata, cmp_val,
                 input  val, flag, pin_out, pin_oe, match);
   modport chan (input  clk_en, tick_run, ovf_evt, brk, ms, en, tov, wr, flag_clr, pin_in, edge_act,
                 cnt, cnt_next, wdata, cmp_val,
                 output val, flag, pin_out, pin_oe, match);
endinterface : tcc_ch_if

`default_nettype wire

// >>> tcc_channel.sv
// Purpose: one input capture / output compare channel
// Assumes: pin input synchronous to clk_sys
// Notes:   edge_act doubles as capture edge select and compare action
`default_nettype none
`include "tcc_timer_map.svh"

module tcc_channel
   import tcc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   tcc_ch_if.chan   ch
);
   logic     pin_prev_reg;
   tcc_cnt_t val_reg;
   logic     flag_reg;
   logic     pin_reg;
   logic     rise;
   logic     fall;
   logic     cap_evt;
   logic     cmp_evt;

   // ------------------------------------------------------------
   // event detection
   // ------------------------------------------------------------
   always_comb begin
      rise    = ch.pin_in & ~pin_prev_reg;
      fall    = ~ch.pin_in & pin_prev_reg;
      cap_evt = ch.clk_en & ch.en & ~ch.ms & ~ch.brk                                  // [R18]
                & ((ch.edge_act[`TCC_EDGE_RISE_BIT] & rise) | (ch.edge_act[`TCC_EDGE_FALL_BIT] & fall)); // [R4]
      cmp_evt = ch.en & ch.ms & ch.tick_run & (ch.cnt_next == ch.cmp_val);            // [R16]
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_prev_reg <= 1'b0;
      end else if (ch.clk_en) begin
         pin_prev_reg <= ch.pin_in;
      end
   end

   // ------------------------------------------------------------
   // value register: capture beats a software write
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         val_reg <= `TCC_VAL_RST;
      end else if (cap_evt) begin
         val_reg <= ch.cnt;                                                           // [R4]
      end else if (ch.clk_en && ch.wr) begin
         val_reg <= ch.wdata;                                                         // [R15]
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flag_reg <= 1'b0;
      end else if (cap_evt || cmp_evt) begin
         flag_reg <= 1'b1;
      end else if (ch.clk_en && ch.flag_clr) begin
         flag_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // pin: compare action wins over toggle on overflow
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_reg <= 1'b0;
      end else if (ch.clk_en && ch.en && ch.ms) begin
         if (cmp_evt) begin
            case (ch.edge_act)                                                        // [R5]
               `TCC_ACT_TOGGLE: pin_reg <= ~pin_reg;
               `TCC_ACT_CLEAR:  pin_reg <= 1'b0;
               `TCC_ACT_SET:    pin_reg <= 1'b1;
               default:         pin_reg <= pin_reg;
            endcase
         end else if (ch.ovf_evt && ch.tov) begin
            pin_reg <= ~pin_reg;                                                      // [R9] [R11]
         end
      end
   end

   assign ch.val     = val_reg;
   assign ch.flag    = flag_reg;
   assign ch.pin_out = pin_reg;
   assign ch.pin_oe  = ch.en & ch.ms & (ch.edge_act != `TCC_ACT_NONE);               // [R1]
   assign ch.match   = cmp_evt;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   cap_store_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R4]
      cap_evt |=> (val_reg == $past(ch.cnt)) && flag_reg)
      else $error("capture did not store counter and flag");
   cmp_action_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R5]
      cmp_evt && ch.clk_en && (ch.edge_act == `TCC_ACT_SET) |=> pin_reg && flag_reg)
      else $error("set on compare not applied");
   tov_toggle_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R9]
      ch.clk_en && ch.en && ch.ms && ch.ovf_evt && ch.tov && !cmp_evt |=> pin_reg != $past(pin_reg))
      else $error("overflow toggle missing");
   brk_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R18]
      ch.brk && !ch.wr |=> $stable(val_reg))
      else $error("capture during break");
   wr_direct_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R15]
      ch.clk_en && ch.wr && !cap_evt |=> val_reg == $past(ch.wdata))
      else $error("write not taken as compare value");
endmodule : tcc_channel

`default_nettype wire

// >>> tcc_timer.sv
// Purpose: 16-bit capture/compare/PWM timer with six channels
// Assumes: all inputs synchronous to clk_sys; control bits are plain ports
// Notes:   channels 0 and 1 form the two-channel subset; channel 0 buffers via channel 1
//
// Functional notes
// [R1] each channel pin capture or compare, independently
// [R2] channel 0 adds buffered compare and PWM
// [R3] six independent channels share one counter
// [R4] capture on rising, falling or either edge
// [R5] compare match sets, clears or toggles pin
// [R6] 16-bit counter, free-running or modulo
// [R7] counter readable anytime without disturbing count
// [R8] seven prescaler divisions or external clock
// [R9] any channel pin may toggle on overflow
// [R10] stop bit halts, reset bit clears counter
// [R11] PWM pin toggles at modulo, period overflow-to-overflow
// [R12] software picks clear or set for polarity
// [R13] period equals modulo plus one prescaled clocks
// [R14] pulse width equals channel value in counts
// [R15] unbuffered write becomes compare value immediately
// [R16] compare on equality only; sync updates
// [R17] status/control: ovf enable, flag, stop, reset, prescale
// [R18] break halts counter and blocks captures
// [R19] modulo reached: wrap to zero, flag overflow
`default_nettype none
`include "tcc_timer_map.svh"

module tcc_timer
   import tcc_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             clk_en,
   input  wire logic             brk_active,
   input  wire logic             ext_clk_in,
   input  wire logic [2:0]       presc_sel,
   input  wire logic             cnt_stop,
   input  wire logic             cnt_rst,
   input  wire logic             ovf_ie,
   input  wire logic             ovf_flag_clr,
   output logic                  ovf_flag,
   output logic                  ovf_irq,
   output logic [15:0]           count_val,
   input  wire logic             mod_wr,
   input  wire logic [15:0]      mod_wdata,
   output logic [15:0]           mod_val,
   input  wire logic             ch0_buffered,
   input  wire logic [5:0]       ch_en,
   input  wire logic [5:0]       ch_ms,
   input  wire logic [5:0][1:0]  ch_edge_act,
   input  wire logic [5:0]       ch_tov,
   input  wire logic [5:0]       ch_val_wr,
   input  wire logic [15:0]      ch_val_wdata,
   input  wire logic [5:0]       ch_flag_clr,
   output logic [5:0]            ch_flag,
   output logic [5:0][15:0]      ch_val,
   input  wire logic [5:0]       ch_pin_in,
   output logic [5:0]            ch_pin_out,
   output logic [5:0]            ch_pin_oe
);
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   tcc_cnt_t  cnt_reg;
   tcc_cnt_t  cnt_next;
   tcc_cnt_t  mod_reg;
   logic [5:0] div_reg;
   logic      ext_prev_reg;
   logic      ovf_flag_reg;
   tcc_bsel_t bsel_reg;
   logic      bpend_reg;
   logic      run;
   logic      tick_int;
   logic      tick_ext;
   logic      tick_run;
   logic      ovf_evt;
   logic      buf_wr_idle;
   logic [5:0] ch_match;

   tcc_ch_if chif [`TCC_NUM_CH] ();

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // divide by 2**sel: tick when the low sel bits of the divider are all ones
   function automatic logic [5:0] div_mask(input logic [2:0] sel);
      logic [6:0] one_hot;
      one_hot  = 7'h01 << sel;
      div_mask = 6'(one_hot - 7'h01);
   endfunction : div_mask

   // ------------------------------------------------------------
   // clock selection and prescaler
   // ------------------------------------------------------------
   // counting is frozen by stop, break and the reset bit alike
   assign run      = clk_en & ~cnt_stop & ~brk_active & ~cnt_rst;                    // [R10] [R18]
   assign tick_int = ((div_reg & div_mask(presc_sel)) == div_mask(presc_sel));        // [R8]
   // ext input has no synchroniser: pins are synchronous; 4 MHz max still gives 2+ samples
   assign tick_ext = ext_clk_in & ~ext_prev_reg;                                      // [R8]
   assign tick_run = run & ((presc_sel == `TCC_PSEL_EXT) ? tick_ext : tick_int);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= `TCC_DIV_RST;
      end else if (clk_en && cnt_rst) begin
         div_reg <= `TCC_DIV_RST;                                                     // [R10]
      end else if (run) begin
         div_reg <= div_reg + 6'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ext_prev_reg <= 1'b0;
      end else if (clk_en) begin
         ext_prev_reg <= ext_clk_in;
      end
   end

   // ------------------------------------------------------------
   // counter and modulo
   // ------------------------------------------------------------
   // modulo reset value all ones makes the counter free-running
   assign ovf_evt  = tick_run & (cnt_reg == mod_reg);                                 // [R19]
   assign cnt_next = (cnt_reg == mod_reg) ? `TCC_CNT_RST : cnt_reg + 16'h0001;        // [R6] [R13]

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= `TCC_CNT_RST;
      end else if (clk_en && cnt_rst) begin
         cnt_reg <= `TCC_CNT_RST;                                                     // [R10]
      end else if (tick_run) begin
         cnt_reg <= cnt_next;                                                         // [R6] [R19]
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mod_reg <= `TCC_MOD_RST;
      end else if (clk_en && mod_wr) begin
         mod_reg <= mod_wdata;                                                        // [R6]
      end
   end

   // ------------------------------------------------------------
   // overflow flag
   // ------------------------------------------------------------
   // a wrap in the clearing cycle keeps the flag set
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ovf_flag_reg <= 1'b0;
      end else if (ovf_evt) begin
         ovf_flag_reg <= 1'b1;                                                        // [R17] [R19]
      end else if (clk_en && ovf_flag_clr) begin
         ovf_flag_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // channel 0 buffering through channel 1
   // ------------------------------------------------------------
   // a write to the idle register is armed and takes over at the next overflow,
   // so a width change never lands mid-period; writes to the live one act at once
   assign buf_wr_idle = (bsel_reg == TCC_BSEL_CH0) ? ch_val_wr[1] : ch_val_wr[0];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bsel_reg  <= TCC_BSEL_CH0;
         bpend_reg <= 1'b0;
      end else if (clk_en) begin
         if (!ch0_buffered) begin
            bsel_reg  <= TCC_BSEL_CH0;
            bpend_reg <= 1'b0;
         end else if (ovf_evt && bpend_reg) begin
            case (bsel_reg)                                                           // [R2]
               TCC_BSEL_CH0: bsel_reg <= TCC_BSEL_CH1;
               TCC_BSEL_CH1: bsel_reg <= TCC_BSEL_CH0;
               default:      bsel_reg <= TCC_BSEL_CH0;
            endcase
            bpend_reg <= 1'b0;
         end else if (buf_wr_idle) begin
            bpend_reg <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // channels
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `TCC_NUM_CH; gi++) begin : g_ch
         assign chif[gi].clk_en   = clk_en;
         assign chif[gi].tick_run = tick_run;
         assign chif[gi].ovf_evt  = ovf_evt;
         assign chif[gi].brk      = brk_active;
         assign chif[gi].ms       = ch_ms[gi];                                        // [R1] [R3]
         assign chif[gi].tov      = ch_tov[gi];
         assign chif[gi].wr       = ch_val_wr[gi];
         assign chif[gi].flag_clr = ch_flag_clr[gi];
         assign chif[gi].pin_in   = ch_pin_in[gi];
         assign chif[gi].edge_act = ch_edge_act[gi];
         assign chif[gi].cnt      = cnt_reg;
         assign chif[gi].cnt_next = cnt_next;
         assign chif[gi].wdata    = ch_val_wdata;
         if (gi == 0) begin : g_buf
            assign chif[gi].en      = ch_en[gi];
            assign chif[gi].cmp_val = (bsel_reg == TCC_BSEL_CH1) ? chif[1].val : chif[0].val; // [R2]
         end else if (gi == 1) begin : g_pair
            // channel 1 pin is released while it serves as channel 0's buffer
            assign chif[gi].en      = ch_en[gi] & ~ch0_buffered;
            assign chif[gi].cmp_val = chif[gi].val;
         end else begin : g_plain
            assign chif[gi].en      = ch_en[gi];
            assign chif[gi].cmp_val = chif[gi].val;                                   // [R14] [R15]
         end

         tcc_channel u_ch (
            .clk_sys (clk_sys),
            .rst_n   (rst_n),
            .ch      (chif[gi])
         );

         assign ch_val[gi]     = chif[gi].val;
         assign ch_flag[gi]    = chif[gi].flag;
         assign ch_pin_out[gi] = chif[gi].pin_out;
         assign ch_pin_oe[gi]  = chif[gi].pin_oe;
         assign ch_match[gi]   = chif[gi].match;
      end
   endgenerate

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign count_val = cnt_reg;                                                        // [R7]
   assign mod_val   = mod_reg;
   assign ovf_flag  = ovf_flag_reg;
   assign ovf_irq   = ovf_flag_reg & ovf_ie;                                          // [R19]

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   ovf_wrap_a: assert property ( // [R19]
      ovf_evt && !cnt_rst |=> (cnt_reg == `TCC_CNT_RST) && ovf_flag_reg)
      else $error("no wrap or flag at modulo");
   cnt_step_a: assert property ( // [R6]
      tick_run && (cnt_reg != mod_reg) |=> cnt_reg == $past(cnt_reg) + 16'h0001)
      else $error("counter did not step by one");
   stop_hold_a: assert property ( // [R10]
      (cnt_stop || brk_active) && !cnt_rst |=> $stable(cnt_reg))
      else $error("counter moved while halted");
   brk_halt_a: assert property ( // [R18]
      brk_active && !cnt_rst |-> !tick_run ##1 $stable(div_reg))
      else $error("prescaler ran during break");
   rst_clear_a: assert property ( // [R10]
      clk_en && cnt_rst |=> (cnt_reg == `TCC_CNT_RST) && (div_reg == `TCC_DIV_RST))
      else $error("counter reset bit ignored");
   div_two_a: assert property ( // [R8]
      clk_en && !cnt_stop && !brk_active && !cnt_rst && (presc_sel == 3'h1) && tick_run
      ##1 clk_en && (presc_sel == 3'h1) |-> !tick_int)
      else $error("divide by two ticked twice");
   irq_gate_a: assert property ( // [R17]
      ovf_evt && ovf_ie |=> ovf_irq [*1] ##0 ovf_flag)
      else $error("overflow did not raise request");
   flag_set_wins_a: assert property ( // [R17]
      ovf_evt && ovf_flag_clr |=> ovf_flag_reg)
      else $error("overflow lost against clear");
   buf_swap_a: assert property ( // [R2]
      clk_en && ch0_buffered && ovf_evt && bpend_reg |=> (bsel_reg != $past(bsel_reg)) && !bpend_reg)
      else $error("buffered register not swapped at overflow");
   pwm_edge_a: assert property ( // [R11]
      clk_en && ch_en[3] && ch_ms[3] && ch_tov[3] && ovf_evt && !ch_match[3]
      |=> ch_pin_out[3] != $past(ch_pin_out[3]))
      else $error("pwm pin not toggled at period end");

   // a low enable must freeze the count, the prescaler phase and the flag
   en_freeze_a: assert property ( // [R6]
      !clk_en |=> $stable(cnt_reg) && $stable(div_reg) && $stable(ovf_flag_reg))
      else $error("state moved with clock enable low");

   // channel 1 only serves as a value store while buffering
   buf_release_a: assert property ( // [R2]
      ch0_buffered |-> !ch_pin_oe[1])
      else $error("buffer channel pin still driven");
endmodule : tcc_timer

`default_nettype wire

// >>> tcc_ext_model.sv
// Purpose: far side of the timer pins: channel pin wires and external counter clock
// Assumes: bench changes pin_drv and ext_run at falling edges
// Notes:   external clock runs at a quarter of clk_sys only while ext_run is high
`default_nettype none

module tcc_ext_model (
   input  wire logic       clk_sys,
   input  wire logic       ext_run,
   input  wire logic [5:0] pin_drv,
   input  wire logic [5:0] pin_out,
   input  wire logic [5:0] pin_oe,
   output logic            ext_clk_in,
   output logic [5:0]      pin_wire
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] ph_reg = 2'h0;

   // ------------------------------------------------------------
   // pin wire level
   // ------------------------------------------------------------
   // a driving channel wins over the outside source
   assign pin_wire = (pin_oe & pin_out) | (~pin_oe & pin_drv);

   // ------------------------------------------------------------
   // external clock
   // ------------------------------------------------------------
   // 2.5 MHz stays under the 4 MHz ceiling; idles low between bursts
   always @(negedge clk_sys) begin
      ph_reg <= ext_run ? ph_reg + 2'h1 : 2'h0;
   end
   assign ext_clk_in = ext_run & ph_reg[1];
endmodule : tcc_ext_model

`default_nettype wire

// >>> tcc_timer_tb_top.sv
// Purpose: self-checking bench of the capture/compare timer
// Assumes: inputs change at falling edges; counter checks use whole prescaler periods
// Notes:   capture values are checked with the counter halted, so they do not hinge on phase
`default_nettype none

module tcc_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic             clk_sys = 1'b0, rst_n = 1'b0, brk_active = 1'b0, cnt_stop = 1'b1, cnt_rst = 1'b0;
   logic             ovf_ie = 1'b1, ovf_flag_clr = 1'b0, mod_wr = 1'b0, ext_run = 1'b0;
   logic             clk_en = 1'b1, ch0_buffered = 1'b0;
   logic [2:0]       presc_sel = 3'h0;
   logic [15:0]      mod_wdata = 16'h0000, ch_val_wdata = 16'h0000, c0;
   logic [5:0]       ch_en = 6'h00, ch_ms = 6'h00, ch_tov = 6'h00, ch_val_wr = 6'h00;
   logic [5:0]       ch_flag_clr = 6'h00, pin_drv = 6'h00;
   logic [5:0][1:0]  ch_edge_act = '0;
   logic             ovf_flag, ovf_irq, ext_clk_in;
   logic [15:0]      count_val, mod_val;
   logic [5:0]       ch_flag, ch_pin_out, ch_pin_oe, pin_wire;
   logic [5:0][15:0] ch_val;
   int               n_errors = 0, checks_done = 0, hi, ex;

   tcc_timer DUT (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .brk_active(brk_active),
      .ext_clk_in(ext_clk_in), .presc_sel(presc_sel), .cnt_stop(cnt_stop), .cnt_rst(cnt_rst),
      .ovf_ie(ovf_ie), .ovf_flag_clr(ovf_flag_clr), .ovf_flag(ovf_flag), .ovf_irq(ovf_irq),
      .count_val(count_val), .mod_wr(mod_wr), .mod_wdata(mod_wdata), .mod_val(mod_val),
      .ch0_buffered(ch0_buffered), .ch_en(ch_en), .ch_ms(ch_ms), .ch_edge_act(ch_edge_act), .ch_tov(ch_tov),
      .ch_val_wr(ch_val_wr), .ch_val_wdata(ch_val_wdata), .ch_flag_clr(ch_flag_clr),
      .ch_flag(ch_flag), .ch_val(ch_val), .ch_pin_in(pin_wire), .ch_pin_out(ch_pin_out),
      .ch_pin_oe(ch_pin_oe));

   tcc_ext_model far_side (.clk_sys(clk_sys), .ext_run(ext_run), .pin_drv(pin_drv),
      .pin_out(ch_pin_out), .pin_oe(ch_pin_oe), .ext_clk_in(ext_clk_in), .pin_wire(pin_wire));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // halts, clears and reprograms in one taken edge, then lets it run
   task automatic restart(input logic [15:0] m, input logic [2:0] sel);
      cnt_stop = 1'b1;
      cnt_rst = 1'b1;
      mod_wdata = m;
      mod_wr = 1'b1;
      presc_sel = sel;
      cyc(1);
      mod_wr = 1'b0;
      cnt_rst = 1'b0;
      cnt_stop = 1'b0;
   endtask : restart

   task automatic wrap_up;
      if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up

   initial begin
      #1_000_000;
      n_errors++;
      wrap_up();
   end

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      cyc(2);
      rst_n = 1'b1;
      chk("count reset", 16'h0000, count_val);
      chk("mod reset", 16'hffff, mod_val);
      chk("ovf_flag reset", 16'h0000, 16'(ovf_flag));
      restart(16'h0002, 3'h0);
      chk("count cleared", 16'h0000, count_val);
      chk("mod_val", 16'h0002, mod_val);
      cyc(1);
      chk("count step", 16'h0001, count_val);
      cyc(2);
      chk("count wrap", 16'h0000, count_val);
      chk("ovf_flag set", 16'h0001, 16'(ovf_flag));
      chk("ovf_irq", 16'h0001, 16'(ovf_irq));
      ovf_flag_clr = 1'b1;
      cyc(1);
      ovf_flag_clr = 1'b0;
      ovf_ie = 1'b0;
      chk("ovf_flag clear", 16'h0000, 16'(ovf_flag));
      cnt_stop = 1'b1;
      c0 = count_val;
      cyc(5);
      chk("count stopped", c0, count_val);
      // delta over whole prescaler periods, so the divider phase does not matter
      for (int s = 0; s < 8; s++) begin
         restart(16'hffff, s[2:0]);
         ext_run = (s == 7);
         cyc(64);
         c0 = count_val;
         cyc(s == 7 ? 32 : 8 << s);
         chk("count per division", c0 + 16'h0008, count_val);
      end
      ext_run = 1'b0;
      restart(16'hffff, 3'h0);
      brk_active = 1'b1;
      ch_en = 6'h04;
      ch_edge_act[2] = 2'h1;
      cyc(1);
      c0 = count_val;
      pin_drv[2] = 1'b1;
      cyc(3);
      chk("count in break", c0, count_val);
      chk("capture in break", 16'h0000, 16'(ch_flag[2]));
      brk_active = 1'b0;
      cnt_stop = 1'b1;
      pin_drv[2] = 1'b0;
      cyc(2);
      c0 = count_val;
      for (int a = 1; a < 4; a++) begin
         ch_edge_act[2] = a[1:0];
         ch_flag_clr[2] = 1'b1;
         cyc(1);
         ch_flag_clr[2] = 1'b0;
         pin_drv[2] = 1'b1;
         cyc(2);
         chk("flag on rise", 16'(a[0]), 16'(ch_flag[2]));
         ch_flag_clr[2] = 1'b1;
         cyc(1);
         ch_flag_clr[2] = 1'b0;
         pin_drv[2] = 1'b0;
         cyc(2);
         chk("flag on fall", 16'(a[1]), 16'(ch_flag[2]));
      end
      chk("captured value", c0, ch_val[2]);
      ch_en = 6'h08;
      ch_ms = 6'h08;
      // toggle alone, clear for high pulses, set for low pulses
      for (int a = 1; a < 4; a++) begin
         ch_edge_act[3] = a[1:0];
         ch_tov[3] = (a != 1);
         ch_val_wdata = 16'h0040;
         ch_val_wr[3] = 1'b1;
         restart(16'h00ff, 3'h0);
         ch_val_wr[3] = 1'b0;
         chk("ch_val written", 16'h0040, ch_val[3]);
         chk("pin driven", 16'h0001, 16'(ch_pin_oe[3]));
         cyc(260);
         hi = 0;
         repeat (512) begin
            cyc(1);
            hi += int'(pin_wire[3]);
         end
         ex = (a == 2) ? 128 : (a == 3) ? 384 : 256;
         chk("pin high cycles", ex[15:0], hi[15:0]);
      end
      // live value 64, armed value 128 takes over at the first overflow
      ch_en = 6'h03;
      ch_ms = 6'h03;
      ch_edge_act[0] = 2'h2;
      ch_edge_act[1] = 2'h1;
      ch_tov[0] = 1'b1;
      ch0_buffered = 1'b1;
      ch_val_wdata = 16'h0040;
      ch_val_wr = 6'h01;
      cyc(1);
      ch_val_wdata = 16'h0080;
      ch_val_wr = 6'h02;
      restart(16'h00ff, 3'h0);
      ch_val_wr = 6'h00;
      chk("buffer pin released", 16'h0000, 16'(ch_pin_oe[1]));
      cyc(260);
      hi = 0;
      repeat (512) begin
         cyc(1);
         hi += int'(pin_wire[0]);
      end
      chk("buffered high cycles", 16'h0100, hi[15:0]);
      clk_en = 1'b0;
      c0 = count_val;
      cyc(4);
      chk("count frozen", c0, count_val);
      clk_en = 1'b1;
      wrap_up();
   end
endmodule : tcc_timer_tb_top

`default_nettype wire
